// File: rirq_regs.sv
// radio interrupt enable, receive status and packet pointer registers
// assumes radio datapath strobes are synchronous one-cycle pulses on aclk
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rirq_regs #(
	parameter int LADDR_W = 3,
	parameter int CRC_W   = 24,
	parameter int IDX_W   = 3,
	parameter int SAMP_W  = 7
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [rirq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output var  logic                        s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output var  logic                        s_axi_wready,
	output var  logic [1:0]                  s_axi_bresp,
	output var  logic                        s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [rirq_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output var  logic                        s_axi_arready,
	output var  logic [31:0]                 s_axi_rdata,
	output var  logic [1:0]                  s_axi_rresp,
	output var  logic                        s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        radio_ready,
	input  wire logic                        radio_address,
	input  wire logic                        radio_payload,
	input  wire logic                        radio_end,
	input  wire logic                        radio_disabled,
	input  wire logic                        device_match_in,
	input  wire logic                        device_miss_in,
	input  wire logic                        sig_sample_done,
	input  wire logic [SAMP_W-1:0]           sig_sample_in,
	input  wire logic                        bit_count_valid,
	input  wire logic [31:0]                 bit_count,
	input  wire logic                        pkt_done,
	input  wire logic                        pkt_crc_pass,
	input  wire logic [LADDR_W-1:0]          pkt_logical_addr,
	input  wire logic [CRC_W-1:0]            pkt_crc_field,
	input  wire logic [IDX_W-1:0]            pkt_match_idx,
	input  wire logic                        xfer_start,
	input  wire logic                        xfer_is_rx,
	output logic [rirq_pkg::NUM_EVENTS-1:0]  event_irq_r,
	output logic [31:0]                      dma_addr_r,
	output logic                             dma_req_r,
	output logic                             dma_write_r
);
	localparam int NE = rirq_pkg::NUM_EVENTS;

	logic                        wr_en, rd_en, wr_err, rd_err;
	logic [rirq_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0]                 wr_data, rd_data, wmask;
	logic [3:0]                  wr_strb;
	logic [NE-1:0]               irq_en_r, irq_en_nxt, set_mask, clr_mask, events, event_irq_nxt;
	logic                        crc_stat_r, crc_stat_nxt;
	logic [LADDR_W-1:0]          rx_laddr_r, rx_laddr_nxt;
	logic [CRC_W-1:0]            rx_crc_r, rx_crc_nxt;
	logic [IDX_W-1:0]            dev_idx_r, dev_idx_nxt;
	logic [31:0]                 pkt_ptr_r, pkt_ptr_nxt, bit_cmp_r, bit_cmp_nxt;
	logic [31:0]                 dma_addr_nxt;
	logic                        dma_req_nxt, dma_write_nxt;
	logic [SAMP_W-1:0]           sig_sample;
	logic                        sig_end_ev, bc_match_ev;

	rirq_axil_slave u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_err),
		.rd_en         (rd_en),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	rirq_event_gen #(
		.SAMP_W (SAMP_W)
	) u_evgen (
		.aclk                      (aclk),
		.aresetn                   (aresetn),
		.sig_sample_done           (sig_sample_done),
		.sig_sample_in             (sig_sample_in),
		.bit_count_valid           (bit_count_valid),
		.bit_count                 (bit_count),
		.bit_counter_compare       (bit_cmp_r),
		.signal_strength_sample    (sig_sample),
		.signal_strength_end_event (sig_end_ev),
		.bit_counter_match_event   (bc_match_ev)
	);

	// byte lanes expanded to a bit mask
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_lane
			assign wmask[gb*8 +: 8] = {8{wr_strb[gb]}};
		end
	endgenerate

	// one event per bit; order fixes the enable bit positions
	always_comb begin
		events                         = '0;
		events[rirq_pkg::EV_READY]     = radio_ready;
		events[rirq_pkg::EV_ADDRESS]   = radio_address;
		events[rirq_pkg::EV_PAYLOAD]   = radio_payload;
		events[rirq_pkg::EV_END]       = radio_end;
		events[rirq_pkg::EV_DISABLED]  = radio_disabled;
		events[rirq_pkg::EV_DEVICE_MATCH_EVENT]  = device_match_in;
		events[rirq_pkg::EV_DEVICE_MISS_EVENT]   = device_miss_in;
		events[rirq_pkg::EV_SIG_END]   = sig_end_ev;
		events[rirq_pkg::EV_BC_MATCH]  = bc_match_ev;
		events[rirq_pkg::EV_CRC_OK]    = pkt_done && pkt_crc_pass;
		events[rirq_pkg::EV_CRC_ERR]   = pkt_done && !pkt_crc_pass;
	end

	// write side and status capture
	always_comb begin
		set_mask     = '0;
		clr_mask     = '0;
		pkt_ptr_nxt  = pkt_ptr_r;
		bit_cmp_nxt  = bit_cmp_r;
		wr_err       = 1'b0;
		if (wr_en) begin
			unique case (wr_addr)
				rirq_pkg::OFS_IRQ_EN:   set_mask = NE'(wr_data & wmask);
				rirq_pkg::OFS_IRQ_DIS:  clr_mask = NE'(wr_data & wmask);
				rirq_pkg::OFS_PKT_PTR:  pkt_ptr_nxt = (pkt_ptr_r & ~wmask) | (wr_data & wmask);
				rirq_pkg::OFS_BIT_CMP:  bit_cmp_nxt = (bit_cmp_r & ~wmask) | (wr_data & wmask);
				rirq_pkg::OFS_CRC_STAT,
				rirq_pkg::OFS_RX_LADDR,
				rirq_pkg::OFS_RX_CRC,
				rirq_pkg::OFS_DEV_IDX,
				rirq_pkg::OFS_SIG_SAMP: wr_err = 1'b0;
				default:                wr_err = 1'b1;
			endcase
		end
		// zero bits leave the shared enable untouched
		irq_en_nxt    = (irq_en_r | set_mask) & ~clr_mask;
		event_irq_nxt = events & irq_en_r;
		crc_stat_nxt  = pkt_done ? pkt_crc_pass : crc_stat_r;
		rx_laddr_nxt  = pkt_done ? pkt_logical_addr : rx_laddr_r;
		rx_crc_nxt    = pkt_done ? pkt_crc_field : rx_crc_r;
		dev_idx_nxt   = pkt_done ? pkt_match_idx : dev_idx_r;
		// pointer sampled at start, so software may reprogram mid-packet
		dma_addr_nxt  = xfer_start ? pkt_ptr_r : dma_addr_r;
		dma_req_nxt   = xfer_start;
		dma_write_nxt = xfer_start ? xfer_is_rx : dma_write_r;
	end

	// read mux; unused upper bits read zero
	always_comb begin
		rd_data = rirq_pkg::RST_WORD;
		rd_err  = 1'b0;
		unique case (s_axi_araddr)
			rirq_pkg::OFS_IRQ_EN,
			rirq_pkg::OFS_IRQ_DIS:  rd_data = 32'(irq_en_r);
			rirq_pkg::OFS_CRC_STAT: rd_data = 32'(crc_stat_r);
			rirq_pkg::OFS_RX_LADDR: rd_data = 32'(rx_laddr_r);
			rirq_pkg::OFS_RX_CRC:   rd_data = 32'(rx_crc_r);
			rirq_pkg::OFS_DEV_IDX:  rd_data = 32'(dev_idx_r);
			rirq_pkg::OFS_PKT_PTR:  rd_data = pkt_ptr_r;
			rirq_pkg::OFS_SIG_SAMP: rd_data = 32'(sig_sample);
			rirq_pkg::OFS_BIT_CMP:  rd_data = bit_cmp_r;
			default:                rd_err  = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_r    <= '0;
			event_irq_r <= '0;
			crc_stat_r  <= 1'b0;
			rx_laddr_r  <= '0;
			rx_crc_r    <= '0;
			dev_idx_r   <= '0;
			pkt_ptr_r   <= rirq_pkg::RST_WORD;
			bit_cmp_r   <= rirq_pkg::RST_WORD;
			dma_addr_r  <= rirq_pkg::RST_WORD;
			dma_req_r   <= 1'b0;
			dma_write_r <= 1'b0;
		end else begin
			irq_en_r    <= irq_en_nxt;
			event_irq_r <= event_irq_nxt;
			crc_stat_r  <= crc_stat_nxt;
			rx_laddr_r  <= rx_laddr_nxt;
			rx_crc_r    <= rx_crc_nxt;
			dev_idx_r   <= dev_idx_nxt;
			pkt_ptr_r   <= pkt_ptr_nxt;
			bit_cmp_r   <= bit_cmp_nxt;
			dma_addr_r  <= dma_addr_nxt;
			dma_req_r   <= dma_req_nxt;
			dma_write_r <= dma_write_nxt;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_dis_clears;
		wr_en && wr_addr == rirq_pkg::OFS_IRQ_DIS |=> (irq_en_r & $past(clr_mask)) == '0;
	endproperty
	a_dis_clears: assert property (p_dis_clears) else $error("disable write left bit on");

	property p_read_enable;
		rd_en && s_axi_araddr == rirq_pkg::OFS_IRQ_DIS |=>
			s_axi_rvalid && s_axi_rdata == 32'($past(irq_en_r));
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

	property p_gate;
		##1 event_irq_r == ($past(events) & $past(irq_en_r));
	endproperty
	a_gate: assert property (p_gate) else $error("event gating wrong");

	property p_sig_end;
		sig_sample_done |=> events[rirq_pkg::EV_SIG_END] && sig_sample == $past(sig_sample_in);
	endproperty
	a_sig_end: assert property (p_sig_end) else $error("sample event missing");

	property p_bc_match;
		bit_count_valid && bit_count == bit_cmp_r |=> events[rirq_pkg::EV_BC_MATCH];
	endproperty
	a_bc_match: assert property (p_bc_match) else $error("bit counter match missing");

	property p_crc_stat;
		pkt_done |=> crc_stat_r == $past(pkt_crc_pass) && rx_crc_r == $past(pkt_crc_field);
	endproperty
	a_crc_stat: assert property (p_crc_stat) else $error("checksum status wrong");

	property p_rx_info;
		pkt_done |=> rx_laddr_r == $past(pkt_logical_addr) && dev_idx_r == $past(pkt_match_idx);
	endproperty
	a_rx_info: assert property (p_rx_info) else $error("receive info wrong");

	property p_ptr_hold;
		// one cycle only: a write may follow at once
		!wr_en |=> $stable(pkt_ptr_r) && $stable(irq_en_r);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("register moved without write");

	property p_dma;
		xfer_start |=> dma_req_r && dma_addr_r == $past(pkt_ptr_r) && dma_write_r == $past(xfer_is_rx);
	endproperty
	a_dma: assert property (p_dma) else $error("buffer address not used");

	c_disable_write: cover property (wr_en && wr_addr == rirq_pkg::OFS_IRQ_DIS && wr_data != '0);
	c_rx_packet: cover property (xfer_start && xfer_is_rx ##[1:20] pkt_done);
	c_irq_out: cover property (event_irq_r != '0);
endmodule : rirq_regs
`default_nettype wire

// File: rirq_pkg.sv
// constants for the radio interrupt enable and receive status register slice
// assumes a 32-bit register bus with word-aligned byte addresses
// Contract
// - writing one to a disable bit turns that event's interrupt off; reset zero
// - reading the disable register returns one for each enabled event
// - eleven event bits: ready through checksum error, each individually controlled
// - signal strength end event fires when a new sample is stored
// - bit counter match event fires when bit count equals programmed compare
// - checksum status reads one for passed last packet, zero for failed
// - received address register shows logical address of last received packet
// - received checksum register holds CRC field of last received packet
// - match index register shows which device address entry matched
// - packet pointer holds buffer address; transmit fetches from it
// - reception stores the packet starting at the packet pointer
// - pointer is byte granular; any alignment is accepted unchanged
package rirq_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          NUM_EVENTS    = 11;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h304;
	localparam logic [11:0] OFS_IRQ_DIS   = 12'h308;
	localparam logic [11:0] OFS_CRC_STAT  = 12'h400;
	localparam logic [11:0] OFS_RX_LADDR  = 12'h408;
	localparam logic [11:0] OFS_RX_CRC    = 12'h40C;
	localparam logic [11:0] OFS_DEV_IDX   = 12'h410;
	localparam logic [11:0] OFS_PKT_PTR   = 12'h504;
	localparam logic [11:0] OFS_SIG_SAMP  = 12'h548;
	localparam logic [11:0] OFS_BIT_CMP   = 12'h560;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// event bit positions in the enable vector
	localparam int EV_READY     = 0;
	localparam int EV_ADDRESS   = 1;
	localparam int EV_PAYLOAD   = 2;
	localparam int EV_END       = 3;
	localparam int EV_DISABLED  = 4;
	localparam int EV_DEVICE_MATCH_EVENT  = 5;
	localparam int EV_DEVICE_MISS_EVENT   = 6;
	localparam int EV_SIG_END   = 7;
	localparam int EV_BC_MATCH  = 8;
	localparam int EV_CRC_OK    = 9;
	localparam int EV_CRC_ERR   = 10;
	localparam logic CRC_PASS   = 1'h1;
endpackage : rirq_pkg

// File: rirq_axil_slave.sv
// axi4-lite slave front end: one write and one read outstanding
// assumes the register core decodes addresses and answers reads combinationally
`timescale 1ns/1ps
`default_nettype none
module rirq_axil_slave (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [rirq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output var  logic                     s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output var  logic                     s_axi_wready,
	output var  logic [1:0]               s_axi_bresp,
	output var  logic                     s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [rirq_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output var  logic                     s_axi_arready,
	output var  logic [31:0]              s_axi_rdata,
	output var  logic [1:0]               s_axi_rresp,
	output var  logic                     s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic                          wr_en,
	output logic [rirq_pkg::ADDR_W-1:0]   wr_addr,
	output logic [31:0]                   wr_data,
	output logic [3:0]                    wr_strb,
	input  wire logic                     wr_err,
	output logic                          rd_en,
	input  wire logic [31:0]              rd_data,
	input  wire logic                     rd_err
);
	logic                        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [rirq_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0]                 wdata_r, wdata_nxt, rdata_nxt;
	logic [3:0]                  wstrb_r, wstrb_nxt;
	logic                        bvalid_nxt, rvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
	logic [1:0]                  bresp_nxt, rresp_nxt;

	assign wr_en   = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_addr = awaddr_r;
	assign wr_data = wdata_r;
	assign wr_strb = wstrb_r;
	assign rd_en   = s_axi_arvalid && s_axi_arready;

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = s_axi_bvalid;
		bresp_nxt   = s_axi_bresp;
		rvalid_nxt  = s_axi_rvalid;
		rresp_nxt   = s_axi_rresp;
		rdata_nxt   = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (wr_en) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_err ? rirq_pkg::RESP_SLVERR : rirq_pkg::RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (rd_en) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_err ? rirq_pkg::RST_WORD : rd_data;
			rresp_nxt  = rd_err ? rirq_pkg::RESP_SLVERR : rirq_pkg::RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		// channels reopen only once the response is gone
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= rirq_pkg::RST_WORD;
			wstrb_r       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= rirq_pkg::RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= rirq_pkg::RESP_OKAY;
			s_axi_rdata   <= rirq_pkg::RST_WORD;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			aw_have_r     <= aw_have_nxt;
			w_have_r      <= w_have_nxt;
			awaddr_r      <= awaddr_nxt;
			wdata_r       <= wdata_nxt;
			wstrb_r       <= wstrb_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rdata   <= rdata_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_arready <= arready_nxt;
		end
	end
endmodule : rirq_axil_slave
`default_nettype wire

// File: rirq_event_gen.sv
// derives the signal strength end and bit counter match events
// assumes the datapath strobes a sample done and a valid bit count
`timescale 1ns/1ps
`default_nettype none
module rirq_event_gen #(
	parameter int SAMP_W = 7
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              sig_sample_done,
	input  wire logic [SAMP_W-1:0] sig_sample_in,
	input  wire logic              bit_count_valid,
	input  wire logic [31:0]       bit_count,
	input  wire logic [31:0]       bit_counter_compare,
	output logic [SAMP_W-1:0]      signal_strength_sample,
	output logic                   signal_strength_end_event,
	output logic                   bit_counter_match_event
);
	logic [SAMP_W-1:0] samp_nxt;
	logic              sig_end_nxt, bc_match_nxt;

	always_comb begin
		samp_nxt     = sig_sample_done ? sig_sample_in : signal_strength_sample;
		// event with the sample, so software never reads a stale value
		sig_end_nxt  = sig_sample_done;
		bc_match_nxt = bit_count_valid && (bit_count == bit_counter_compare);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			signal_strength_sample    <= '0;
			signal_strength_end_event <= 1'b0;
			bit_counter_match_event   <= 1'b0;
		end else begin
			signal_strength_sample    <= samp_nxt;
			signal_strength_end_event <= sig_end_nxt;
			bit_counter_match_event   <= bc_match_nxt;
		end
	end
endmodule : rirq_event_gen
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the radio interrupt enable and receive status slice
// assumes rirq_regs alone, driven over axi4-lite and by event pulses from the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  rsp;
	} rirq_row_t;

	logic        aclk;
	logic        aresetn;
	logic [11:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [11:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [10:0] ev_pulse;
	logic [6:0]  samp;
	logic [2:0]  laddr;
	logic [23:0] crc_fld;
	logic [2:0]  midx;
	logic [31:0] bcnt;
	logic        xfer_start;
	logic        xfer_is_rx;
	logic [10:0] event_irq_r;
	logic [31:0] dma_addr_r;
	logic        dma_req_r;
	logic        dma_write_r;
	int          err_count;
	int          n_tests;
	rirq_row_t   rows [6];

	rirq_regs dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.radio_ready(ev_pulse[0]), .radio_address(ev_pulse[1]), .radio_payload(ev_pulse[2]),
		.radio_end(ev_pulse[3]), .radio_disabled(ev_pulse[4]),
		.device_match_in(ev_pulse[5]), .device_miss_in(ev_pulse[6]),
		.sig_sample_done(ev_pulse[7]), .sig_sample_in(samp),
		.bit_count_valid(ev_pulse[8]), .bit_count(bcnt),
		.pkt_done(ev_pulse[9] | ev_pulse[10]), .pkt_crc_pass(ev_pulse[9]),
		.pkt_logical_addr(laddr), .pkt_crc_field(crc_fld), .pkt_match_idx(midx),
		.xfer_start(xfer_start), .xfer_is_rx(xfer_is_rx),
		.event_irq_r(event_irq_r), .dma_addr_r(dma_addr_r),
		.dma_req_r(dma_req_r), .dma_write_r(dma_write_r)
	);

	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// master holds each channel until its own handshake edge
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done;
		bit w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(d, e);
	endtask : rd_chk

	task automatic tally_and_finish;
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// generous bound: whole run is a few hundred cycles
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [10:0] acc;
		logic [31:0] st;
		aresetn = 1'h0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, ev_pulse} = '0;
		{samp, laddr, crc_fld, midx, bcnt, xfer_start, xfer_is_rx} = '0;
		err_count = 0;
		n_tests = 0;
		st = 32'h0000_0000;
		rows[0] = '{rirq_pkg::OFS_IRQ_EN, 32'h0000_07FF, 32'h0000_07FF, 2'h0};
		rows[1] = '{rirq_pkg::OFS_IRQ_DIS, 32'h0000_0005, 32'h0000_07FA, 2'h0};
		rows[2] = '{rirq_pkg::OFS_IRQ_DIS, 32'h0000_0000, 32'h0000_07FA, 2'h0};
		rows[3] = '{rirq_pkg::OFS_PKT_PTR, 32'h2000_0003, 32'h2000_0003, 2'h0};
		rows[4] = '{rirq_pkg::OFS_CRC_STAT, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0};
		rows[5] = '{12'h0F0, 32'h1234_5678, 32'h0000_0000, 2'h2};
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, r);
			chk({30'h0, r}, {30'h0, rows[i].rsp});
			axr(rows[i].a, d, r);
			chk(d, rows[i].e);
			chk({30'h0, r}, {30'h0, rows[i].rsp});
		end
		axw(rirq_pkg::OFS_BIT_CMP, 32'h0000_0123, r);
		@(posedge aclk);
		samp <= 7'h55;
		laddr <= 3'h5;
		crc_fld <= 24'hABCDEF;
		midx <= 3'h6;
		// ready and payload were disabled above, so their pulses must stay silent
		// last pass repeats the counter pulse with a count one off the compare
		for (int i = 0; i < 12; i++) begin
			@(posedge aclk);
			ev_pulse <= 11'h001 << ((i == 11) ? 8 : i);
			bcnt <= (i == 11) ? 32'h0000_0124 : 32'h0000_0123;
			@(posedge aclk);
			ev_pulse <= 11'h000;
			acc = '0;
			repeat (4) begin
				#1 acc = acc | event_irq_r;
				@(posedge aclk);
			end
			chk({21'h0, acc}, (i == 11) ? 32'h0 : {21'h0, (11'h001 << i) & 11'h7FA});
			if (i == 9) st = 32'h0000_0001;
			if (i == 10) st = 32'h0000_0000;
			rd_chk(rirq_pkg::OFS_CRC_STAT, st);
		end
		rd_chk(rirq_pkg::OFS_SIG_SAMP, 32'h0000_0055);
		rd_chk(rirq_pkg::OFS_RX_LADDR, 32'h0000_0005);
		rd_chk(rirq_pkg::OFS_RX_CRC, 32'h00AB_CDEF);
		rd_chk(rirq_pkg::OFS_DEV_IDX, 32'h0000_0006);
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk);
			xfer_start <= 1'h1;
			xfer_is_rx <= k[0];
			@(posedge aclk);
			xfer_start <= 1'h0;
			#1 chk({31'h0, dma_req_r}, 32'h0000_0001);
			@(posedge aclk);
			#1 chk(dma_addr_r, 32'h2000_0003);
			chk({31'h0, dma_write_r}, {31'h0, k[0]});
			chk({31'h0, dma_req_r}, 32'h0000_0000);
		end
		// second reset in mid-run must clear enables and pointer
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd_chk(rirq_pkg::OFS_IRQ_DIS, 32'h0000_0000);
		rd_chk(rirq_pkg::OFS_PKT_PTR, 32'h0000_0000);
		rd_chk(rirq_pkg::OFS_CRC_STAT, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
